// *** design/pump_sup_defines.svh ***
// Purpose: offsets, field slices, codes and limits of the pump supervisor
// Assumes: 32-bit apb data, pressures in 0.01 psi, times in 0.1 s ticks
// Notes:   field macros expand to part-select ranges or single bit indices
`ifndef PUMP_SUP_DEFINES_SVH
`define PUMP_SUP_DEFINES_SVH
`define OFS_CTRL    8'h00
`define OFS_PRESS   8'h04
`define OFS_LIMIT   8'h08
`define OFS_TOLSLP  8'h0c
`define OFS_PIDG    8'h10
`define OFS_TIMEA   8'h14
`define OFS_TIMEB   8'h18
`define OFS_TIMEC   8'h1c
`define OFS_LOSSP   8'h20
`define OFS_STATUS  8'h24
`define F_FUNC      1:0
`define F_ROLE      4:2
`define F_CMDSRC    5
`define F_DISP      7:6
`define F_FSRC      11:8
`define F_PIDEN     12
`define F_CMODE     15:13
`define F_LO16      15:0
`define F_HI16      31:16
`define F_SLPF      27:16
`define F_KP        9:0
`define F_TI        19:10
`define F_TD        29:20
`define F_TLO       12:0
`define F_THI       28:16
`define F_PROP      9:0
`define FUNC_OFF    2'h0
`define FUNC_PUMP   2'h1
`define FUNC_HVAC   2'h2
`define FUNC_COMP   2'h3
`define ROLE_MAX    3'h4
`define DISP_MAX    2'h2
`define DISP_BOTH   2'h0
`define DISP_TGT    2'h1
`define DISP_FB     2'h2
`define FSRC_PID    4'h5
`define CMODE_VF    3'h0
`define P_MIN       16'h000a
`define P_MAX       16'hfde8
`define P_TEN       16'h03e8
`define SLPF_MAX    12'h708
`define GAIN_MAX    10'h3e8
`define T_SLP_MAX   13'h09fb
`define T_255_MAX   13'h09f6
`define T_600_MAX   13'h1770
`define T_ONE       13'h0001
`define PROP_FULL   26'h00003e8
`define TICK_TIME_US 100000
`define CLK_PERIOD_NS 100
`define NTMR        6
`define T_SLP       0
`define T_HW        1
`define T_HS        2
`define T_LW        3
`define T_LS        4
`define T_LOSS      5
`endif

// *** design/pump_sup_pkg.sv ***
// Purpose: types shared by the pump supervisor and its bench
// Assumes: pump_sup_defines.svh holds the numbers
// Notes:   output groups travel as packed structs
package pump_sup_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_SLEEP} sleep_state_type;
    typedef struct packed {
        logic        pid_active;
        logic        comp_active;
        logic [15:0] pressure_cmd;
        logic        lower_freq;
        logic        raise_freq;
        logic        decel_req;
        logic        sleeping;
        logic        stop_req;
        logic        high_pressure_warning;
        logic        high_pressure_fault;
        logic        low_pressure_warning;
        logic        low_pressure_fault;
        logic        feedback_loss_fault;
        logic        vf_fixed;
        logic        curve_hidden;
        logic [15:0] mid_volt;
        logic [2:0]  role;
        logic [9:0]  kp;
        logic [9:0]  ti;
        logic [9:0]  td;
    } drive_type;
    typedef struct packed {
        logic        show_target;
        logic        show_feedback;
        logic        split;
        logic        kilo_unit;
        logic        integer_target;
        logic [15:0] target;
        logic [15:0] feedback;
    } disp_type;
endpackage : pump_sup_pkg

// *** design/pump_pressure_supervisor.sv ***
// Purpose: constant-pressure pump supervision with apb register access
// Assumes: feedback, analog input and frequency come from clk logic
// Notes:   link_ok is an asynchronous pin and is synchronised
`timescale 1ns/1ps
`include "pump_sup_defines.svh"
// Behaviour
// R01: function code 0 off, 1 pump, 2 hvac, 3 compressor; target only if selected
// R02: pump or hvac acts only with pid frequency source and pid enabled
// R03: compressor: no pid source, fixed v/f, curve hidden, mid volt half
// R04: pump or compressor selection refused unless control mode is v/f
// R05: role 0 single, 1 master, 2..4 slaves; applied after reconnection
// R06: setpoint kept in 0.10..650.00 psi and never above maximum pressure
// R07: pressure command from stored setpoint or analog input
// R08: display both, target only or feedback only
// R09: hvac display unit stands for one thousand flow units
// R10: target above ten shown as integer
// R11: pid gain and times range limited, writable while running
// R12: lower frequency above setpoint, restart pid below setpoint minus tolerance
// R13: sleep timer runs while frequency below sleep threshold
// R14: sleep timer expiry ramps down with primary decel then sleeps
// R15: high pressure warning timer restarts when feedback drops
// R16: high pressure stop timer after warning, fault and stop on expiry
// R17: zero high warning time disables high pressure supervision
// R18: low pressure warning timer restarts when feedback rises
// R19: low pressure stop timer after warning, fault and stop on expiry
// R20: zero low warning time disables low pressure supervision
// R21: feedback below setpoint times proportion for loss time raises fault
// R22: timers count 0.1 s ticks and clear when their condition ends
module pump_pressure_supervisor
    import pump_sup_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_TIME_US * 1000 / `CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] feedback,
    input  wire logic [15:0] analog_pressure_input,
    input  wire logic [11:0] out_freq,
    input  wire logic [15:0] max_volt,
    input  wire logic        link_ok,
    output drive_type        drive_o,
    output disp_type         disp_o
);
    typedef struct packed {
        logic [1:0]             func;
        logic [2:0]             role_pend;
        logic                   cmd_src;
        logic [1:0]             disp_sel;
        logic [3:0]             freq_src;
        logic                   pid_en;
        logic [2:0]             ctrl_mode;
        logic [15:0]            op_p;
        logic [15:0]            max_p;
        logic [15:0]            hi_lim;
        logic [15:0]            lo_lim;
        logic [15:0]            tol;
        logic [11:0]            sleep_f;
        logic [9:0]             kp;
        logic [9:0]             ti;
        logic [9:0]             td;
        logic [12:0]            sleep_t;
        logic [12:0]            loss_t;
        logic [12:0]            hw_t;
        logic [12:0]            hs_t;
        logic [12:0]            lw_t;
        logic [12:0]            ls_t;
        logic [9:0]             loss_prop;
        logic                   reject;
        logic                   link_s1;
        logic                   link_s2;
        logic                   link_s3;
        logic [19:0]            tick_cnt;
        logic [`NTMR-1:0][12:0] tmr;
        sleep_state_type        slp;
        logic                   press_high;
        drive_type              drv;
        disp_type               dsp;
        logic [31:0]            rdata;
        logic                   rdy;
        logic                   err;
    } state_type;

    localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

    state_type              s_q;
    state_type              s_d;
    logic [`NTMR-1:0]       run;
    logic [`NTMR-1:0]       expire;
    logic [`NTMR-1:0][12:0] lim;
    logic                   pump_on;
    logic                   comp_on;
    logic                   pid_sel;
    logic [15:0]            sp;
    logic [15:0]            tgt;
    logic                   hi_en;
    logic                   lo_en;
    logic                   above_hi;
    logic                   below_lo;
    logic                   loss_low;
    logic                   below_band;

    function automatic logic [15:0] sat16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        sat16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : sat16

    function automatic logic [12:0] sat13(input logic [12:0] v,
                                          input logic [12:0] hi);
        sat13 = (v > hi) ? hi : v;
    endfunction : sat13

    function automatic logic [9:0] sat10(input logic [9:0] v);
        sat10 = (v > `GAIN_MAX) ? `GAIN_MAX : v;
    endfunction : sat10

    // function enables
    assign pid_sel = (s_q.freq_src == `FSRC_PID) && s_q.pid_en; // see R02
    assign pump_on = ((s_q.func == `FUNC_PUMP) || (s_q.func == `FUNC_HVAC))
                     && pid_sel; // see R01
    assign comp_on = (s_q.func == `FUNC_COMP)
                     && (s_q.freq_src != `FSRC_PID); // see R03
    assign sp  = (s_q.op_p > s_q.max_p) ? s_q.max_p : s_q.op_p; // see R06
    assign tgt = !pump_on ? 16'h0000
               : (s_q.cmd_src ? analog_pressure_input : sp); // see R07
    assign below_band = ({1'b0, feedback} + {1'b0, s_q.tol})
                        < {1'b0, tgt}; // see R12
    assign hi_en    = pump_on && (s_q.hw_t != 13'h0000); // see R17
    assign lo_en    = pump_on && (s_q.lw_t != 13'h0000); // see R20
    assign above_hi = feedback > s_q.hi_lim;
    assign below_lo = feedback < s_q.lo_lim;
    assign loss_low = (26'(feedback) * `PROP_FULL)
                      < (26'(tgt) * 26'(s_q.loss_prop)); // see R21

    // timer start conditions and lengths
    assign run[`T_SLP]  = pump_on && (s_q.slp == ST_RUN)
                          && (out_freq < s_q.sleep_f); // see R13
    assign run[`T_HW]   = hi_en && above_hi
                          && !s_q.drv.high_pressure_warning; // see R15
    assign run[`T_HS]   = hi_en && above_hi && s_q.drv.high_pressure_warning
                          && !s_q.drv.high_pressure_fault; // see R16
    assign run[`T_LW]   = lo_en && below_lo
                          && !s_q.drv.low_pressure_warning; // see R18
    assign run[`T_LS]   = lo_en && below_lo && s_q.drv.low_pressure_warning
                          && !s_q.drv.low_pressure_fault; // see R19
    assign run[`T_LOSS] = pump_on && (s_q.loss_prop != 10'h000) && loss_low
                          && !s_q.drv.feedback_loss_fault; // see R21
    assign lim[`T_SLP]  = s_q.sleep_t;
    assign lim[`T_HW]   = s_q.hw_t;
    assign lim[`T_HS]   = s_q.hs_t;
    assign lim[`T_LW]   = s_q.lw_t;
    assign lim[`T_LS]   = s_q.ls_t;
    assign lim[`T_LOSS] = s_q.loss_t;

    // one compare per timer
    genvar gi;
    generate
        for (gi = 0; gi < `NTMR; gi++) begin : g_tmr
            assign expire[gi] = run[gi] && (s_q.tmr[gi] >= lim[gi]);
        end
    endgenerate

    always_comb begin
        logic        tick;
        logic        acc;
        logic [1:0]  nfunc;
        logic [31:0] sts;
        s_d   = s_q;
        tick  = (s_q.tick_cnt == TICK_LAST);
        acc   = psel && penable && s_q.rdy;
        nfunc = pwdata[`F_FUNC];
        sts   = {24'h000000, s_q.slp == ST_SLEEP, s_q.drv.role != 3'h0,
                 s_q.reject, s_q.drv.feedback_loss_fault,
                 s_q.drv.low_pressure_fault, s_q.drv.low_pressure_warning,
                 s_q.drv.high_pressure_fault, s_q.drv.high_pressure_warning};
        s_d.link_s1  = link_ok;
        s_d.link_s2  = s_q.link_s1;
        s_d.link_s3  = s_q.link_s2;
        s_d.tick_cnt = tick ? 20'h00000 : s_q.tick_cnt + 20'h00001;
        // apb slave: answer in the access cycle after every setup
        s_d.rdy = psel && !penable;
        s_d.err = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                `OFS_CTRL:   s_d.rdata = {16'h0000, s_q.ctrl_mode,
                                 s_q.pid_en, s_q.freq_src, s_q.disp_sel,
                                 s_q.cmd_src, s_q.role_pend, s_q.func};
                `OFS_PRESS:  s_d.rdata = {s_q.max_p, s_q.op_p};
                `OFS_LIMIT:  s_d.rdata = {s_q.lo_lim, s_q.hi_lim};
                `OFS_TOLSLP: s_d.rdata = {4'h0, s_q.sleep_f, s_q.tol};
                `OFS_PIDG:   s_d.rdata = {2'h0, s_q.td, s_q.ti, s_q.kp};
                `OFS_TIMEA:  s_d.rdata = {3'h0, s_q.loss_t, 3'h0, s_q.sleep_t};
                `OFS_TIMEB:  s_d.rdata = {3'h0, s_q.hs_t, 3'h0, s_q.hw_t};
                `OFS_TIMEC:  s_d.rdata = {3'h0, s_q.ls_t, 3'h0, s_q.lw_t};
                `OFS_LOSSP:  s_d.rdata = {22'h000000, s_q.loss_prop};
                `OFS_STATUS: s_d.rdata = sts;
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.err   = 1'b1;
                end
            endcase
        end
        if (acc && pwrite) begin
            case (paddr)
                `OFS_CTRL: begin
                    if ((nfunc == `FUNC_PUMP || nfunc == `FUNC_COMP)
                        && pwdata[`F_CMODE] != `CMODE_VF) begin
                        s_d.reject = 1'b1; // see R04
                    end else begin
                        s_d.func = nfunc;
                    end
                    if (pwdata[`F_ROLE] <= `ROLE_MAX) begin
                        s_d.role_pend = pwdata[`F_ROLE]; // see R05
                    end
                    if (pwdata[`F_DISP] <= `DISP_MAX) begin
                        s_d.disp_sel = pwdata[`F_DISP];
                    end
                    s_d.cmd_src   = pwdata[`F_CMDSRC];
                    s_d.freq_src  = pwdata[`F_FSRC];
                    s_d.pid_en    = pwdata[`F_PIDEN];
                    s_d.ctrl_mode = pwdata[`F_CMODE];
                end
                `OFS_PRESS: begin
                    s_d.max_p = sat16(pwdata[`F_HI16], `P_MIN, `P_MAX);
                    s_d.op_p  = sat16(pwdata[`F_LO16], `P_MIN,
                                      sat16(pwdata[`F_HI16], `P_MIN,
                                            `P_MAX)); // see R06
                end
                `OFS_LIMIT: begin
                    s_d.hi_lim = sat16(pwdata[`F_LO16], `P_MIN, `P_MAX);
                    s_d.lo_lim = sat16(pwdata[`F_HI16], `P_MIN, `P_MAX);
                end
                `OFS_TOLSLP: begin
                    s_d.tol     = sat16(pwdata[`F_LO16], `P_MIN, `P_MAX);
                    s_d.sleep_f = (pwdata[`F_SLPF] > `SLPF_MAX)
                                ? `SLPF_MAX : pwdata[`F_SLPF]; // see R13
                end
                `OFS_PIDG: begin
                    s_d.kp = sat10(pwdata[`F_KP]); // see R11
                    s_d.ti = sat10(pwdata[`F_TI]);
                    s_d.td = sat10(pwdata[`F_TD]);
                end
                `OFS_TIMEA: begin
                    s_d.sleep_t = sat13(pwdata[`F_TLO], `T_SLP_MAX); // see R14
                    s_d.loss_t  = sat13(pwdata[`F_THI], `T_600_MAX);
                end
                `OFS_TIMEB: begin
                    s_d.hw_t = sat13(pwdata[`F_TLO], `T_255_MAX);
                    s_d.hs_t = (pwdata[`F_THI] < `T_ONE) ? `T_ONE
                             : sat13(pwdata[`F_THI], `T_255_MAX);
                end
                `OFS_TIMEC: begin
                    s_d.lw_t = sat13(pwdata[`F_TLO], `T_255_MAX);
                    s_d.ls_t = sat13(pwdata[`F_THI], `T_600_MAX);
                end
                `OFS_LOSSP: begin
                    s_d.loss_prop = sat10(pwdata[`F_PROP]);
                end
                `OFS_STATUS: begin
                    // write one to clear; hardware sets below win
                    if (pwdata[0]) s_d.drv.high_pressure_warning = 1'b0;
                    if (pwdata[1]) s_d.drv.high_pressure_fault = 1'b0;
                    if (pwdata[2]) s_d.drv.low_pressure_warning = 1'b0;
                    if (pwdata[3]) s_d.drv.low_pressure_fault = 1'b0;
                    if (pwdata[4]) s_d.drv.feedback_loss_fault = 1'b0;
                    if (pwdata[5]) s_d.reject = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // role takes effect on a new connection
        if (s_q.link_s2 && !s_q.link_s3) begin
            s_d.drv.role = s_q.role_pend; // see R05
        end
        // timers
        for (int i = 0; i < `NTMR; i++) begin
            if (!run[i]) begin
                s_d.tmr[i] = 13'h0000; // see R22
            end else if (tick && s_q.tmr[i] != 13'h1fff) begin
                s_d.tmr[i] = s_q.tmr[i] + 13'h0001; // see R22
            end
        end
        if (expire[`T_HW])   s_d.drv.high_pressure_warning = 1'b1; // see R15
        if (expire[`T_HS])   s_d.drv.high_pressure_fault = 1'b1; // see R16
        if (expire[`T_LW])   s_d.drv.low_pressure_warning = 1'b1; // see R18
        if (expire[`T_LS])   s_d.drv.low_pressure_fault = 1'b1; // see R19
        if (expire[`T_LOSS]) s_d.drv.feedback_loss_fault = 1'b1; // see R21
        // pressure band with tolerance hysteresis
        if (!pump_on || below_band) begin
            s_d.press_high = 1'b0; // see R12
        end else if (feedback > tgt) begin
            s_d.press_high = 1'b1; // see R12
        end
        // sleep sequence
        case (s_q.slp)
            ST_RUN: begin
                if (expire[`T_SLP]) s_d.slp = ST_DECEL; // see R14
            end
            ST_DECEL: begin
                if (!pump_on || below_band) s_d.slp = ST_RUN;
                else if (out_freq == 12'h000) s_d.slp = ST_SLEEP; // see R14
            end
            ST_SLEEP: begin
                if (!pump_on || below_band) s_d.slp = ST_RUN; // see R12
            end
            default: s_d.slp = ST_RUN;
        endcase
        // registered outputs
        s_d.drv.pid_active   = pump_on;
        s_d.drv.comp_active  = comp_on;
        s_d.drv.pressure_cmd = tgt;
        s_d.drv.lower_freq   = pump_on && s_q.press_high; // see R12
        s_d.drv.raise_freq   = pump_on && !s_q.press_high;
        s_d.drv.decel_req    = s_q.slp == ST_DECEL; // see R14
        s_d.drv.sleeping     = s_q.slp == ST_SLEEP;
        s_d.drv.stop_req     = s_q.drv.high_pressure_fault
                             || s_q.drv.low_pressure_fault
                             || s_q.drv.feedback_loss_fault; // see R16
        s_d.drv.vf_fixed     = comp_on; // see R03
        s_d.drv.curve_hidden = comp_on;
        s_d.drv.mid_volt     = comp_on ? (max_volt >> 1) : 16'h0000;
        s_d.drv.kp           = s_q.kp;
        s_d.drv.ti           = s_q.ti;
        s_d.drv.td           = s_q.td;
        s_d.dsp.show_target   = s_q.disp_sel != `DISP_FB; // see R08
        s_d.dsp.show_feedback = s_q.disp_sel != `DISP_TGT;
        s_d.dsp.split         = s_q.disp_sel == `DISP_BOTH;
        s_d.dsp.kilo_unit     = s_q.func == `FUNC_HVAC; // see R09
        s_d.dsp.integer_target = tgt > `P_TEN; // see R10
        s_d.dsp.target        = tgt;
        s_d.dsp.feedback      = feedback;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q           <= '0;
            s_q.op_p      <= `P_MIN;
            s_q.max_p     <= `P_MAX;
            s_q.hi_lim    <= `P_MAX;
            s_q.lo_lim    <= `P_MIN;
            s_q.tol       <= `P_MIN;
            s_q.hs_t      <= `T_ONE;
            s_q.slp       <= ST_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.rdata;
    assign pready  = s_q.rdy;
    assign pslverr = s_q.err;
    assign drive_o = s_q.drv;
    assign disp_o  = s_q.dsp;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    func_reject_a: assert property ( // see R04
        psel && penable && pready && pwrite && paddr == `OFS_CTRL
        && pwdata[`F_CMODE] != `CMODE_VF && pwdata[`F_FUNC] == `FUNC_PUMP
        |=> s_q.func == $past(s_q.func) && s_q.reject)
        else $error("pump selected outside v/f mode");
    pid_gate_a: assert property ( // see R02
        drive_o.pid_active |-> $past(s_q.freq_src) == `FSRC_PID
        && $past(s_q.pid_en))
        else $error("pump active without pid source");
    comp_half_a: assert property ( // see R03
        drive_o.vf_fixed |-> drive_o.curve_hidden
        && drive_o.mid_volt == ($past(max_volt) >> 1))
        else $error("compressor mid voltage wrong");
    setp_clamp_a: assert property ( // see R06
        drive_o.pid_active && !$past(s_q.cmd_src)
        |-> drive_o.pressure_cmd <= $past(s_q.max_p))
        else $error("setpoint above maximum pressure");
    cmd_source_a: assert property ( // see R07
        drive_o.pid_active && $past(s_q.cmd_src)
        |-> drive_o.pressure_cmd == $past(analog_pressure_input))
        else $error("analog command not used");
    disp_mode_a: assert property ( // see R08
        s_q.disp_sel == `DISP_TGT |=> !disp_o.show_feedback
        && disp_o.show_target && !disp_o.split)
        else $error("target only display wrong");
    hi_restart_a: assert property ( // see R15
        s_q.tmr[`T_HW] != 13'h0000 && !(feedback > s_q.hi_lim)
        |=> s_q.tmr[`T_HW] == 13'h0000)
        else $error("high warning timer not restarted");
    hi_off_a: assert property ( // see R17
        s_q.hw_t == 13'h0000 |=> s_q.tmr[`T_HW] == 13'h0000
        && s_q.tmr[`T_HS] == 13'h0000)
        else $error("high supervision not disabled");
    lo_off_a: assert property ( // see R20
        s_q.lw_t == 13'h0000 |=> s_q.tmr[`T_LW] == 13'h0000
        && s_q.tmr[`T_LS] == 13'h0000)
        else $error("low supervision not disabled");
    loss_off_a: assert property ( // see R21
        s_q.loss_prop == 10'h000 |=> s_q.tmr[`T_LOSS] == 13'h0000)
        else $error("loss timer runs with zero proportion");
    stop_fault_a: assert property ( // see R16
        $rose(drive_o.high_pressure_fault) |=> drive_o.stop_req)
        else $error("fault without stop");

    hi_fault_c: cover property ($rose(drive_o.high_pressure_fault));
    lo_fault_c: cover property ($rose(drive_o.low_pressure_fault));
    sleep_c:    cover property ($rose(drive_o.sleeping));
    loss_c:     cover property ($rose(drive_o.feedback_loss_fault));
endmodule : pump_pressure_supervisor

// *** tb/pressure_xmtr.sv ***
// Purpose: pressure transmitter feeding the supervisor
// Assumes: shares the supervisor clock
// Notes:   output follows the bench level one cycle later
`timescale 1ns/1ps
module pressure_xmtr (
    input  wire logic        clk,
    input  wire logic [15:0] level,
    output logic      [15:0] feedback
);
    always_ff @(posedge clk) begin
        feedback <= level;
    end
endmodule : pressure_xmtr

// *** tb/pump_pressure_supervisor_tb_top.sv ***
// Purpose: register and supervision tests of the pump supervisor
// Assumes: tick shortened to 4 clocks
// Notes:   apb master changes signals right after rising edges
`timescale 1ns/1ps
`include "pump_sup_defines.svh"
module pump_pressure_supervisor_tb_top;
    import pump_sup_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, link_ok = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic [15:0] lvl = 16'h0, feedback, max_volt = 16'h0100;
    logic [15:0] analog_pressure_input = 16'h2222;
    logic [11:0] out_freq = 12'hfff;
    drive_type   drive_o;
    disp_type    disp_o;
    int          n_fail = 0, n_tests = 0;
    always #50 clk = ~clk;
    pressure_xmtr i_pressure_xmtr (.clk, .level(lvl), .feedback);
    pump_pressure_supervisor #(.TICK_CYCLES(4)) i_pump_pressure_supervisor (
        .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .feedback, .analog_pressure_input, .out_freq,
        .max_volt, .link_ok, .drive_o, .disp_o);
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic print_verdict;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        #(100 * 3000); n_fail++; print_verdict;
    end
    initial begin
        wt(16); rst_b <= 1'b1; wt(2);
        apb(0, `OFS_PRESS, 0); chk(rd, 32'hfde8_000a);
        apb(0, `OFS_LIMIT, 0); chk(rd, 32'h000a_fde8);
        apb(0, 8'h28, 0); chk({err, rd}, 33'h1_0000_0000);
        $display("registers done");
        apb(1, `OFS_CTRL, 32'h0003); wt(3);
        chk({drive_o.comp_active, drive_o.vf_fixed, drive_o.curve_hidden,
            drive_o.pid_active, drive_o.mid_volt}, {4'he, 16'h0080});
        apb(1, `OFS_PRESS, 32'hfde8_1388);
        for (int d = 0; d < 3; d++) begin
            apb(1, `OFS_CTRL, 32'h1501 | (d << 6)); wt(3);
            chk({disp_o.split, disp_o.show_target, disp_o.show_feedback},
                {d == 0, d != 2, d != 1});
        end
        chk({drive_o.pid_active, disp_o.kilo_unit, disp_o.integer_target,
            drive_o.pressure_cmd}, {3'b101, 16'h1388});
        apb(1, `OFS_CTRL, 32'h1502); wt(3); chk(disp_o.kilo_unit, 1);
        apb(1, `OFS_CTRL, 32'h1521); wt(3); chk(drive_o.pressure_cmd, 16'h2222);
        apb(1, `OFS_CTRL, 32'h0501); wt(3); chk(drive_o.pid_active, 0);
        apb(1, `OFS_CTRL, 32'h1501);
        apb(1, `OFS_PRESS, 32'h07d0_0fa0); wt(3); chk(drive_o.pressure_cmd, 16'h07d0);
        apb(1, `OFS_CTRL, 32'h2001); apb(0, `OFS_STATUS, 0); chk(rd[5], 1);
        apb(1, `OFS_CTRL, 32'h1501);
        $display("function select done");
        apb(1, `OFS_LIMIT, 32'h0010_1000); apb(1, `OFS_TIMEB, 32'h0001_0003);
        lvl <= 16'h2000; wt(6); lvl <= 16'h0; wt(2); lvl <= 16'h2000; wt(11);
        chk(drive_o.high_pressure_warning, 0);
        wt(40);
        chk({drive_o.high_pressure_warning, drive_o.high_pressure_fault,
            drive_o.stop_req}, 3'b111);
        lvl <= 16'h0005; wt(40); chk(drive_o.low_pressure_warning, 0);
        apb(1, `OFS_TIMEC, 32'h0000_0002); wt(30);
        chk(drive_o.low_pressure_warning, 1);
        chk(drive_o.low_pressure_fault, 1);
        apb(1, `OFS_PIDG, 32'h3fff_ffff); wt(3);
        chk({drive_o.kp, drive_o.ti, drive_o.td}, {3{10'h3e8}});
        apb(1, `OFS_LOSSP, 32'h0000_01f4); wt(4);
        chk(drive_o.feedback_loss_fault, 1);
        apb(1, `OFS_CTRL, 32'h1509); wt(6);
        chk(drive_o.role, 3'h0);
        link_ok <= 1'b0; wt(4);
        link_ok <= 1'b1; wt(6);
        chk(drive_o.role, 3'h2);
        apb(0, `OFS_STATUS, 0); chk(rd[6], 1);
        $display("pid, loss and role done");
        lvl <= 16'h0800;
        apb(1, `OFS_TOLSLP, 32'h0010_000a);
        apb(1, `OFS_TIMEA, 32'h0000_0002);
        chk(drive_o.lower_freq, 1);
        out_freq <= 12'h005; wt(20);
        chk(drive_o.decel_req, 1);
        out_freq <= 12'h000; wt(3);
        chk(drive_o.sleeping, 1);
        lvl <= 16'h0000; wt(4);
        chk({drive_o.sleeping, drive_o.raise_freq}, 2'b01);
        $display("sleep done");
        $display("supervision done");
        print_verdict;
    end
endmodule : pump_pressure_supervisor_tb_top
